// ---- verilog/sdci_consts.svh ----
// constants for the synchronous dram command interface, both ends
`ifndef SDCI_CONSTS_SVH
`define SDCI_CONSTS_SVH
// ***************************************
// clock and timing
// ***************************************
`define SDCI_CLK_NS 8
`define SDCI_CYC(ns) (((ns) + `SDCI_CLK_NS - 1) / `SDCI_CLK_NS)
`define SDCI_INIT_NS 200000
`define SDCI_INIT_CYC `SDCI_CYC(`SDCI_INIT_NS)
`define SDCI_RCD_NS 20
`define SDCI_RP_NS 20
`define SDCI_RC_NS 60
`define SDCI_RRD_NS 12
`define SDCI_RAS_NS 42
`define SDCI_RSC_NS 16
`define SDCI_REFI_NS 7800
`define SDCI_INIT_REFRESHES 4'h8
// ***************************************
// command codes as {row strobe, column strobe, write strobe}
// ***************************************
`define SDCI_CMD_MRS 3'h0
`define SDCI_CMD_REF 3'h1
`define SDCI_CMD_PRE 3'h2
`define SDCI_CMD_ACT 3'h3
`define SDCI_CMD_WR 3'h4
`define SDCI_CMD_RD 3'h5
`define SDCI_CMD_NOP 3'h7
`define SDCI_ALL_BANKS 10
// ***************************************
// mode register fields
// ***************************************
`define SDCI_MR_BL_HI 2
`define SDCI_MR_BL_LO 0
`define SDCI_MR_BT 3
`define SDCI_MR_CL_HI 6
`define SDCI_MR_CL_LO 4
`define SDCI_MODE_RST 13'h0030
`define SDCI_CL2 3'h2
// ***************************************
// controller register offsets and fields
// ***************************************
`define SDCI_REG_CTRL 8'h00
`define SDCI_REG_ADDR 8'h04
`define SDCI_REG_WDATA 8'h08
`define SDCI_REG_RDATA 8'h0C
`define SDCI_REG_STATUS 8'h10
`define SDCI_REG_MODE 8'h14
`define SDCI_CTRL_GO 0
`define SDCI_CTRL_WR 1
`define SDCI_ROW_HI 12
`define SDCI_COL_HI 24
`define SDCI_COL_LO 16
`define SDCI_WMASK_HI 17
`define SDCI_WMASK_LO 16
`endif

// ---- verilog/sdci_pkg.sv ----
// types and burst helpers shared by both ends
`include "sdci_consts.svh"
package sdci_pkg;
	typedef enum logic [3:0] {C_WAIT, C_PREALL, C_REF, C_MRS, C_IDLE, C_ACT, C_ACCESS,
		C_PRE} sdci_cstate_t;

	// number of words in a burst for a mode value
	function automatic logic [9:0] sdci_burst_len(input logic [12:0] mode);
		case (mode[`SDCI_MR_BL_HI:`SDCI_MR_BL_LO])
			3'h0: return 10'h001;
			3'h1: return 10'h002;
			3'h2: return 10'h004;
			3'h3: return 10'h008;
			3'h7: return 10'h200;
			default: return 10'h001;
		endcase
	endfunction : sdci_burst_len

	// column of word i of a burst, wrapping inside the burst block
	function automatic logic [8:0] sdci_burst_col(input logic [8:0] base, input logic [8:0] i,
		input logic [12:0] mode);
		logic [8:0] wrap;
		wrap = 9'(sdci_burst_len(mode) - 10'h001);
		if (mode[`SDCI_MR_BT])
			return base ^ (i & wrap);
		return (base & ~wrap) | (9'(base + i) & wrap);
	endfunction : sdci_burst_col
endpackage : sdci_pkg

// ---- verilog/sdci_if.sv ----
// pin bundle between the memory controller and the dram device
`timescale 1ns/1ns
interface sdci_if (input wire logic pclk);
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic cke;
	logic [1:0] bank_select;
	logic [12:0] addr;
	logic low_byte_mask;
	logic high_byte_mask;
	logic [15:0] ctl_dq_o;
	logic ctl_dq_oe;
	logic [15:0] dev_dq_o;
	logic [1:0] dev_dq_oe;
	logic [15:0] data_lines;

	// resolved level of the shared data lines, per byte lane
	assign data_lines[7:0] = dev_dq_oe[0] ? dev_dq_o[7:0] : (ctl_dq_oe ? ctl_dq_o[7:0] : 8'h00);
	assign data_lines[15:8] = dev_dq_oe[1] ? dev_dq_o[15:8] :
		(ctl_dq_oe ? ctl_dq_o[15:8] : 8'h00);

	modport ctrl (input pclk, input data_lines, output cs_n, output ras_n, output cas_n,
		output we_n, output cke, output bank_select, output addr, output low_byte_mask,
		output high_byte_mask, output ctl_dq_o, output ctl_dq_oe);
	modport dev (input pclk, input data_lines, input cs_n, input ras_n, input cas_n,
		input we_n, input cke, input bank_select, input addr, input low_byte_mask,
		input high_byte_mask, output dev_dq_o, output dev_dq_oe);
endinterface : sdci_if

// ---- verilog/sdci_dev.sv ----
// dram device end: command decoder, banks, bursts and data pins
`timescale 1ns/1ns
`include "sdci_consts.svh"
module sdci_dev (
	sdci_if.dev mem,
	input wire logic presetn,
	output logic [12:0] mode_value,
	output logic power_down,
	output logic self_refresh
);
	import sdci_pkg::*;

	logic [15:0] store [0:(1 << 24) - 1];
	logic cke_q;
	logic en;
	logic take;
	logic [2:0] cmd;
	logic [3:0] row_open;
	logic [12:0] row_of [0:3];
	logic burst_on;
	logic burst_wr;
	logic [1:0] burst_bank;
	logic [8:0] burst_base;
	logic [9:0] burst_idx;
	logic [9:0] burst_len;
	logic go;
	logic go_wr;
	logic [1:0] cur_bank;
	logic [8:0] cur_base;
	logic [9:0] cur_idx;
	logic [23:0] cur_loc;
	logic [1:0] mask;
	logic [1:0] mask_q;
	logic [16:0] pipe0;
	logic [16:0] pipe1;

	// ***************************************
	// command decode
	// ***************************************
	// clock gate low at the last edge freezes this edge
	assign en = cke_q & ~self_refresh;
	assign take = en & ~mem.cs_n;
	assign cmd = {mem.ras_n, mem.cas_n, mem.we_n};
	assign mask = {mem.high_byte_mask, mem.low_byte_mask};

	// current burst word: a new access restarts at word zero
	always_comb begin
		go = take & (cmd == `SDCI_CMD_RD || cmd == `SDCI_CMD_WR);
		go_wr = go ? (cmd == `SDCI_CMD_WR) : burst_wr;
		cur_bank = go ? mem.bank_select : burst_bank;
		cur_base = go ? mem.addr[8:0] : burst_base;
		cur_idx = go ? 10'h000 : burst_idx;
		cur_loc = {cur_bank, row_of[cur_bank],
			sdci_burst_col(cur_base, cur_idx[8:0], mode_value)};
	end

	// clock gate history and low power states
	always_ff @(posedge mem.pclk or negedge presetn) begin
		if (!presetn) begin
			cke_q <= 1'b1;
			power_down <= 1'b0;
			self_refresh <= 1'b0;
		end else begin
			cke_q <= mem.cke;
			power_down <= ~mem.cke & ~burst_on & ~self_refresh;
			if (mem.cke)
				self_refresh <= 1'b0;
			else if (take && cmd == `SDCI_CMD_REF)
				self_refresh <= 1'b1;
		end
	end

	// mode register and open rows per bank
	always_ff @(posedge mem.pclk or negedge presetn) begin
		if (!presetn) begin
			mode_value <= `SDCI_MODE_RST;
			row_open <= 4'h0;
			for (int b = 0; b < 4; b++)
				row_of[b] <= 13'h0000;
		end else if (take) begin
			case (cmd)
				`SDCI_CMD_MRS: mode_value <= mem.addr;
				`SDCI_CMD_ACT: begin
					row_open[mem.bank_select] <= 1'b1;
					row_of[mem.bank_select] <= mem.addr;
				end
				`SDCI_CMD_PRE: begin
					if (mem.addr[`SDCI_ALL_BANKS])
						row_open <= 4'h0;
					else
						row_open[mem.bank_select] <= 1'b0;
				end
				default: row_open <= row_open;
			endcase
		end
	end

	// ***************************************
	// bursts
	// ***************************************
	// burst state advances one word per enabled edge
	always_ff @(posedge mem.pclk or negedge presetn) begin
		if (!presetn) begin
			burst_on <= 1'b0;
			burst_wr <= 1'b0;
			burst_bank <= 2'h0;
			burst_base <= 9'h000;
			burst_idx <= 10'h000;
			burst_len <= 10'h001;
		end else if (go) begin
			burst_wr <= go_wr;
			burst_bank <= cur_bank;
			burst_base <= cur_base;
			burst_idx <= 10'h001;
			burst_len <= sdci_burst_len(mode_value);
			burst_on <= sdci_burst_len(mode_value) != 10'h001;
		end else if (en && burst_on) begin
			burst_idx <= burst_idx + 10'h001;
			burst_on <= (burst_idx + 10'h001) != burst_len;
		end
	end

	// write data is taken in the cycle of its word, masked bytes skipped
	always_ff @(posedge mem.pclk) begin
		if ((go || (en && burst_on)) && go_wr) begin
			if (!mask[0])
				store[cur_loc][7:0] <= mem.data_lines[7:0];
			if (!mask[1])
				store[cur_loc][15:8] <= mem.data_lines[15:8];
		end
	end

	// read pipeline: word fetched at its edge, driven out latency later
	always_ff @(posedge mem.pclk or negedge presetn) begin
		if (!presetn) begin
			pipe0 <= 17'h00000;
			pipe1 <= 17'h00000;
			mask_q <= 2'h3;
			mem.dev_dq_o <= 16'h0000;
			mem.dev_dq_oe <= 2'h0;
		end else if (en) begin
			pipe0 <= {(go || burst_on) && !go_wr, store[cur_loc]};
			pipe1 <= pipe0;
			mask_q <= mask;
			if (mode_value[`SDCI_MR_CL_HI:`SDCI_MR_CL_LO] == `SDCI_CL2) begin
				mem.dev_dq_o <= pipe0[15:0];
				mem.dev_dq_oe <= {2{pipe0[16]}} & ~mask_q;
			end else begin
				mem.dev_dq_o <= pipe1[15:0];
				mem.dev_dq_oe <= {2{pipe1[16]}} & ~mask_q;
			end
		end
	end
endmodule : sdci_dev

// ---- verilog/sdci_ctrl.sv ----
// memory controller end: apb registers and dram command sequencer
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "sdci_consts.svh"
// ***************************************
// Summary of operation
// - row on thirteen lines, column on nine
// - bank select names activated or accessed bank
// - chip select high ignores new commands
// - strobes decoded at each rising edge
// - byte mask: read two late, write immediate
// - clock gate low enters low power states
// - mode register always programmed before use
// - initial pause with masks, gate high
// - precharge all, then program mode register
// - eight auto refreshes during initialization
// - mode set only precharged, gate high
// - mode set: all strobes low, address
// - wait mode set recovery before next command
// - activate, then wait before access
// - precharge between activates, row cycle spacing
// - activates spaced by bank to bank delay
// - close row before maximum open time
// - read and write strobe encodings
// - new row needs precharge then activate
// - access accepted on every cycle
// - burst order and length from mode
// - write data with command, then per edge
// - read latency two or three
// ***************************************
module sdci_ctrl #(
	parameter int INIT_CYCLES = `SDCI_INIT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	sdci_if.ctrl mem
);
	import sdci_pkg::*;

	localparam logic [23:0] RCD = 24'(`SDCI_CYC(`SDCI_RCD_NS));
	localparam logic [23:0] RP = 24'(`SDCI_CYC(`SDCI_RP_NS));
	localparam logic [23:0] RC = 24'(`SDCI_CYC(`SDCI_RC_NS));
	localparam logic [23:0] RRD = 24'(`SDCI_CYC(`SDCI_RRD_NS));
	localparam logic [23:0] RAS = 24'(`SDCI_CYC(`SDCI_RAS_NS));
	localparam logic [23:0] RSC = 24'(`SDCI_CYC(`SDCI_RSC_NS));
	localparam logic [23:0] REFI = 24'(`SDCI_REFI_NS / `SDCI_CLK_NS);
	localparam logic [23:0] GAP = (RC > RRD) ? RC : RRD;

	sdci_cstate_t state;
	sdci_cstate_t after;
	logic [23:0] wait_cnt;
	logic [23:0] act_gap;
	logic [23:0] refi_cnt;
	logic ref_due;
	logic [3:0] ref_left;
	logic init_done;
	logic req;
	logic [2:0] cmd;
	logic [31:0] ctrl_reg;
	logic [31:0] addr_reg;
	logic [31:0] wdata_reg;
	logic [12:0] mode_reg;
	logic [15:0] rdata;
	logic rd_valid;
	logic [3:0] cap_cnt;
	logic [2:0] cl;
	logic [23:0] acc_wait;
	logic fin;
	logic wr_fin;
	logic rd_fin;
	logic mapped;
	logic [31:0] rd_word;

	// ***************************************
	// apb slave
	// ***************************************
	assign fin = psel & penable & pready;
	assign wr_fin = fin & pwrite;
	assign rd_fin = fin & ~pwrite;
	assign mapped = paddr == `SDCI_REG_CTRL || paddr == `SDCI_REG_ADDR ||
		paddr == `SDCI_REG_WDATA || paddr == `SDCI_REG_RDATA ||
		paddr == `SDCI_REG_STATUS || paddr == `SDCI_REG_MODE;

	// read multiplexer, unmapped reads zero
	always_comb begin
		case (paddr)
			`SDCI_REG_CTRL: rd_word = ctrl_reg;
			`SDCI_REG_ADDR: rd_word = addr_reg;
			`SDCI_REG_WDATA: rd_word = wdata_reg;
			`SDCI_REG_RDATA: rd_word = {16'h0000, rdata};
			`SDCI_REG_STATUS: rd_word = {29'h00000000, rd_valid, init_done,
				req | (state != C_IDLE)};
			`SDCI_REG_MODE: rd_word = {19'h00000, mode_reg};
			default: rd_word = 32'h00000000;
		endcase
	end

	// one wait state; writes land on the edge that completes the access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			ctrl_reg <= 32'h00000000;
			addr_reg <= 32'h00000000;
			wdata_reg <= 32'h00000000;
			mode_reg <= `SDCI_MODE_RST;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (psel && penable && !pready)
				prdata <= rd_word;
			if (wr_fin) begin
				case (paddr)
					`SDCI_REG_CTRL: begin
						// frozen while an access is pending, so a refused go cannot retarget it
						if (!req)
							ctrl_reg <= {28'h0000000, pwdata[3:0]};
					end
					`SDCI_REG_ADDR: addr_reg <= pwdata;
					`SDCI_REG_WDATA: wdata_reg <= pwdata;
					`SDCI_REG_MODE: mode_reg <= pwdata[12:0];
					default: ctrl_reg <= ctrl_reg;
				endcase
			end
		end
	end

	// ***************************************
	// command sequencer
	// ***************************************
	assign cl = mode_reg[`SDCI_MR_CL_HI:`SDCI_MR_CL_LO] == `SDCI_CL2 ? 3'h2 : 3'h3;
	assign acc_wait = (24'(cl) + 24'h000002 > RAS - RCD) ? 24'(cl) + 24'h000002 : RAS - RCD;
	assign mem.cs_n = 1'b0;
	assign mem.ras_n = cmd[2];
	assign mem.cas_n = cmd[1];
	assign mem.we_n = cmd[0];

	// one command per state; C_WAIT spaces it from the next
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= C_WAIT;
			after <= C_PREALL;
			wait_cnt <= 24'(INIT_CYCLES - 1);
			act_gap <= 24'h000000;
			refi_cnt <= 24'h000000;
			ref_due <= 1'b0;
			ref_left <= 4'h0;
			init_done <= 1'b0;
			req <= 1'b0;
			cmd <= `SDCI_CMD_NOP;
			mem.cke <= 1'b1;
			mem.bank_select <= 2'h0;
			mem.addr <= 13'h0000;
			mem.low_byte_mask <= 1'b1;
			mem.high_byte_mask <= 1'b1;
			mem.ctl_dq_o <= 16'h0000;
			mem.ctl_dq_oe <= 1'b0;
		end else begin
			cmd <= `SDCI_CMD_NOP;
			mem.cke <= 1'b1;
			mem.ctl_dq_oe <= 1'b0;
			mem.low_byte_mask <= ~init_done;
			mem.high_byte_mask <= ~init_done;
			if (act_gap != 24'h000000)
				act_gap <= act_gap - 24'h000001;
			if (refi_cnt == REFI - 24'h000001) begin
				refi_cnt <= 24'h000000;
				ref_due <= init_done;
			end else begin
				refi_cnt <= refi_cnt + 24'h000001;
			end
			// a go queues behind a refresh; a pending access or an unfinished start-up refuses it
			if (wr_fin && paddr == `SDCI_REG_CTRL && pwdata[`SDCI_CTRL_GO] && !req &&
				init_done)
				req <= 1'b1;
			case (state)
				C_WAIT: begin
					if (wait_cnt == 24'h000000)
						state <= after;
					else
						wait_cnt <= wait_cnt - 24'h000001;
				end
				C_PREALL: begin
					cmd <= `SDCI_CMD_PRE;
					mem.addr <= 13'h0001 << `SDCI_ALL_BANKS;
					ref_left <= `SDCI_INIT_REFRESHES;
					state <= C_WAIT;
					wait_cnt <= RP - 24'h000002;
					after <= C_REF;
				end
				C_REF: begin
					cmd <= `SDCI_CMD_REF;
					ref_left <= ref_left - 4'h1;
					state <= C_WAIT;
					wait_cnt <= RC - 24'h000002;
					if (ref_left != 4'h1)
						after <= C_REF;
					else
						after <= init_done ? C_IDLE : C_MRS;
				end
				C_MRS: begin
					cmd <= `SDCI_CMD_MRS;
					mem.addr <= mode_reg;
					init_done <= 1'b1;
					state <= C_WAIT;
					wait_cnt <= RSC - 24'h000002;
					after <= C_IDLE;
				end
				C_IDLE: begin
					if (ref_due) begin
						ref_due <= 1'b0;
						ref_left <= 4'h1;
						state <= C_REF;
					end else if (req && act_gap == 24'h000000) begin
						state <= C_ACT;
					end
				end
				C_ACT: begin
					cmd <= `SDCI_CMD_ACT;
					mem.bank_select <= ctrl_reg[3:2];
					mem.addr <= addr_reg[`SDCI_ROW_HI:0];
					act_gap <= GAP - 24'h000001;
					state <= C_WAIT;
					wait_cnt <= RCD - 24'h000002;
					after <= C_ACCESS;
				end
				C_ACCESS: begin
					cmd <= ctrl_reg[`SDCI_CTRL_WR] ? `SDCI_CMD_WR : `SDCI_CMD_RD;
					mem.addr <= {4'h0, addr_reg[`SDCI_COL_HI:`SDCI_COL_LO]};
					mem.ctl_dq_oe <= ctrl_reg[`SDCI_CTRL_WR];
					mem.ctl_dq_o <= wdata_reg[15:0];
					mem.low_byte_mask <= ctrl_reg[`SDCI_CTRL_WR] & wdata_reg[`SDCI_WMASK_LO];
					mem.high_byte_mask <= ctrl_reg[`SDCI_CTRL_WR] & wdata_reg[`SDCI_WMASK_HI];
					req <= 1'b0;
					state <= C_WAIT;
					wait_cnt <= acc_wait - 24'h000002;
					after <= C_PRE;
				end
				C_PRE: begin
					cmd <= `SDCI_CMD_PRE;
					mem.addr <= 13'h0000;
					state <= C_WAIT;
					wait_cnt <= RP - 24'h000002;
					after <= C_IDLE;
				end
				default: state <= C_IDLE;
			endcase
		end
	end

	// read capture at the programmed latency; a new word wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_cnt <= 4'h0;
			rdata <= 16'h0000;
			rd_valid <= 1'b0;
		end else begin
			if (state == C_ACCESS && !ctrl_reg[`SDCI_CTRL_WR])
				cap_cnt <= 4'(cl) + 4'h1;
			else if (cap_cnt != 4'h0)
				cap_cnt <= cap_cnt - 4'h1;
			if (cap_cnt == 4'h1) begin
				rdata <= mem.data_lines;
				rd_valid <= 1'b1;
			end else if (rd_fin && paddr == `SDCI_REG_RDATA) begin
				rd_valid <= 1'b0;
			end
		end
	end
endmodule : sdci_ctrl

// ---- sim/sdci_asserts.sv ----
// concurrent checks on the command and data link between the two ends
`timescale 1ns/1ns
`include "sdci_consts.svh"
module sdci_asserts #(
	parameter int INIT_CYCLES = 40
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic cke,
	input wire logic [1:0] bank_select,
	input wire logic [12:0] addr,
	input wire logic low_byte_mask,
	input wire logic high_byte_mask,
	input wire logic ctl_dq_oe,
	input wire logic [1:0] dev_dq_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [2:0] cmd;
	logic [15:0] pause_cnt;
	logic seen_cmd;
	logic [3:0] ref_cnt;
	logic mode_set;
	logic [12:0] mode_cap;
	logic [3:0] bank_open;
	logic rd_cl2;
	logic rd_cl3;
	// ***************************************
	// helper state
	// ***************************************
	// decoded command, a deselected cycle reads as idle
	assign cmd = cs_n ? `SDCI_CMD_NOP : {ras_n, cas_n, we_n};
	assign rd_cl2 = cmd == `SDCI_CMD_RD && mode_cap[`SDCI_MR_CL_HI:`SDCI_MR_CL_LO] == `SDCI_CL2 &&
		mode_cap[`SDCI_MR_BL_HI:`SDCI_MR_BL_LO] == 3'h0;
	assign rd_cl3 = cmd == `SDCI_CMD_RD && mode_cap[`SDCI_MR_CL_HI:`SDCI_MR_CL_LO] == 3'h3 &&
		mode_cap[`SDCI_MR_BL_HI:`SDCI_MR_BL_LO] == 3'h0;
	// progress of the start-up sequence and the latched mode value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pause_cnt <= 16'h0000;
			seen_cmd <= 1'b0;
			ref_cnt <= 4'h0;
			mode_set <= 1'b0;
			mode_cap <= `SDCI_MODE_RST;
		end else begin
			if (pause_cnt != 16'hFFFF) pause_cnt <= pause_cnt + 16'h0001;
			if (cmd != `SDCI_CMD_NOP) seen_cmd <= 1'b1;
			if (cmd == `SDCI_CMD_REF && ref_cnt != 4'hF) ref_cnt <= ref_cnt + 4'h1;
			if (cmd == `SDCI_CMD_MRS) mode_set <= 1'b1;
			if (cmd == `SDCI_CMD_MRS) mode_cap <= addr;
		end
	end
	// banks left open by activates, closed by precharges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) bank_open <= 4'h0;
		else if (cmd == `SDCI_CMD_ACT) bank_open[bank_select] <= 1'b1;
		else if (cmd == `SDCI_CMD_PRE && addr[`SDCI_ALL_BANKS]) bank_open <= 4'h0;
		else if (cmd == `SDCI_CMD_PRE) bank_open[bank_select] <= 1'b0;
	end
	// ***************************************
	// properties
	// ***************************************
	sequence s_act;
		cmd == `SDCI_CMD_ACT;
	endsequence
	sequence s_mrs;
		cmd == `SDCI_CMD_MRS;
	endsequence
	sequence s_no_access;
		cmd != `SDCI_CMD_RD && cmd != `SDCI_CMD_WR;
	endsequence
	pause_idle_a: assert property (pause_cnt < 16'(INIT_CYCLES - 1) |->
		cmd == `SDCI_CMD_NOP && cke && low_byte_mask && high_byte_mask)
		else $error("activity during the initial pause");
	first_precharge_a: assert property (cmd != `SDCI_CMD_NOP && !seen_cmd |->
		cmd == `SDCI_CMD_PRE && addr[`SDCI_ALL_BANKS])
		else $error("first command is not a precharge of all banks");
	act_after_init_a: assert property (s_act |-> mode_set && ref_cnt >= 4'h8)
		else $error("activate before mode set and refreshes");
	mode_set_cond_a: assert property (s_mrs |-> cke && $past(cke) && bank_open == 4'h0)
		else $error("mode set with an open bank or gated clock");
	mode_recovery_a: assert property (s_mrs |=> cmd == `SDCI_CMD_NOP)
		else $error("command inside mode set recovery");
	act_access_gap_a: assert property (s_act |=> s_no_access [*2])
		else $error("access too soon after activate");
	row_cycle_a: assert property (s_act |=> (cmd != `SDCI_CMD_ACT) [*7])
		else $error("activates closer than the row cycle");
	act_closed_a: assert property (s_act |-> !bank_open[bank_select])
		else $error("activate to a bank that is still open");
	row_close_a: assert property (s_act |-> ##[1:40] cmd == `SDCI_CMD_PRE)
		else $error("row left open too long");
	write_data_a: assert property (cmd == `SDCI_CMD_WR |-> ctl_dq_oe && dev_dq_oe == 2'h0)
		else $error("write word not driven with the write command");
	read_cl3_a: assert property (rd_cl3 |-> ##3
		dev_dq_oe == ~{$past(high_byte_mask, 2), $past(low_byte_mask, 2)} ##1 dev_dq_oe == 2'h0)
		else $error("read word timing wrong at latency three");
	read_cl2_a: assert property (rd_cl2 |-> ##2
		dev_dq_oe == ~{$past(high_byte_mask, 2), $past(low_byte_mask, 2)} ##1 dev_dq_oe == 2'h0)
		else $error("read word timing wrong at latency two");
endmodule : sdci_asserts

// ---- sim/tb_top.sv ----
// self-checking bench: apb traffic into the controller, device on the far end
`timescale 1ns/1ns
`include "sdci_consts.svh"
module tb_top;
	localparam int INIT_CYC = 40;
	localparam int LIMIT = 12000;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [12:0] mode_value;
	logic power_down;
	int num_errors = 0;
	int cmp_count = 0;
	int cycle_cnt = 0;
	logic [1:0] bk [8];
	logic [12:0] row [8];
	logic [8:0] col [8];
	logic [15:0] dat [8];
	logic [15:0] nw;
	logic [31:0] q;
	logic e;
	// ***************************************
	// design and checker
	// ***************************************
	sdci_if u_sdci_if (.pclk(pclk));
	sdci_ctrl #(.INIT_CYCLES(INIT_CYC)) u_sdci_ctrl (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .mem(u_sdci_if));
	sdci_dev u_sdci_dev (.mem(u_sdci_if), .presetn(presetn), .mode_value(mode_value),
		.power_down(power_down), .self_refresh());
	sdci_asserts #(.INIT_CYCLES(INIT_CYC)) u_sdci_asserts (.pclk(pclk), .presetn(presetn),
		.cs_n(u_sdci_if.cs_n), .ras_n(u_sdci_if.ras_n), .cas_n(u_sdci_if.cas_n),
		.we_n(u_sdci_if.we_n), .cke(u_sdci_if.cke), .bank_select(u_sdci_if.bank_select),
		.addr(u_sdci_if.addr), .low_byte_mask(u_sdci_if.low_byte_mask),
		.high_byte_mask(u_sdci_if.high_byte_mask), .ctl_dq_oe(u_sdci_if.ctl_dq_oe),
		.dev_dq_oe(u_sdci_if.dev_dq_oe));
	// free-running clock, 8 ns period
	always #4 pclk = ~pclk;
	// ***************************************
	// helpers
	// ***************************************
	// cycle ceiling so a hang still ends in a verdict
	always @(posedge pclk) begin
		cycle_cnt <= cycle_cnt + 1;
		if (cycle_cnt == LIMIT) begin
			num_errors++;
			final_report();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report
	// expected word after a write with byte masks {high, low}
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nwd,
		input logic [1:0] msk);
		return {msk[1] ? old[15:8] : nwd[15:8], msk[0] ? old[7:0] : nwd[7:0]};
	endfunction : merge
	// one apb transfer; request held until pready, result left in q and e
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// poll status until start-up is done and the sequencer is free
	task automatic wait_idle();
		do apb(1'b0, `SDCI_REG_STATUS, 32'h0); while (q[1:0] !== 2'b10);
	endtask : wait_idle
	task automatic mem_op(input logic wr, input int i, input logic [17:0] wd);
		apb(1'b1, `SDCI_REG_ADDR, {7'h00, col[i], 3'h0, row[i]});
		apb(1'b1, `SDCI_REG_WDATA, {14'h0000, wd});
		apb(1'b1, `SDCI_REG_CTRL, {28'h0000000, bk[i], wr, 1'b1});
		wait_idle();
	endtask : mem_op
	task automatic read_check(input int i);
		mem_op(1'b0, i, 18'h00000);
		apb(1'b0, `SDCI_REG_STATUS, 32'h0);
		check("read valid", {31'h0, q[2]}, 32'h1);
		apb(1'b0, `SDCI_REG_RDATA, 32'h0);
		check("read word", q, {16'h0000, dat[i]});
		apb(1'b0, `SDCI_REG_STATUS, 32'h0);
		check("read valid cleared", {31'h0, q[2]}, 32'h0);
	endtask : read_check
	// ***************************************
	// one run from reset with a given mode value
	// ***************************************
	task automatic phase(input logic [12:0] m);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `SDCI_REG_MODE, 32'h0);
		check("mode reset value", q, {19'h0, `SDCI_MODE_RST});
		apb(1'b1, `SDCI_REG_MODE, {19'h0, m});
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped data", q, 32'h0);
		check("unmapped error", {31'h0, e}, 32'h1);
		wait_idle();
		check("mode programmed", {19'h0, mode_value}, {19'h0, m});
		check("power state", {31'h0, power_down}, 32'h0);
		// every bank, edge rows and columns, second row of each bank on the same column
		for (int i = 0; i < 8; i++) begin
			bk[i] = 2'(i);
			row[i] = (i < 4) ? 13'($urandom) : ~row[i - 4];
			col[i] = (i < 4) ? 9'($urandom) : col[i - 4];
			if (i < 2) row[i] = {13{i[0]}};
			if (i < 2) col[i] = {9{i[0]}};
			dat[i] = 16'($urandom);
			mem_op(1'b1, i, {2'b00, dat[i]});
		end
		// a second go while busy must be dropped
		apb(1'b1, `SDCI_REG_CTRL, {28'h0000000, bk[7], 1'b1, 1'b1});
		apb(1'b1, `SDCI_REG_CTRL, {28'h0000000, bk[7], 1'b0, 1'b1});
		wait_idle();
		apb(1'b0, `SDCI_REG_STATUS, 32'h0);
		check("go while busy", {31'h0, q[2]}, 32'h0);
		// low byte masked on entry 0, high byte masked on entry 1
		for (int j = 0; j < 2; j++) begin
			nw = 16'($urandom);
			mem_op(1'b1, j, {2'(j + 1), nw});
			dat[j] = merge(dat[j], nw, 2'(j + 1));
		end
		for (int i = 0; i < 8; i++) read_check(i);
	endtask : phase
	// ***************************************
	// main sequence
	// ***************************************
	initial begin
		void'($urandom(32'h02EDA72E));
		phase(`SDCI_MODE_RST);
		phase(13'h0020);
		// interleaved bursts of four: the extra words land beside each entry, never on one
		phase(13'h002A);
		final_report();
	end
endmodule : tb_top
